// [bench/rpc_checker_chk.sv]
// rpc_checker_chk.sv: port assertions for the region checker
// assumes: bound into rpc_checker, one clock domain
`include "rpc_map.vh"
module rpc_checker_chk (
  // clock and reset
  input wire CORE_CLK_I,
  input wire RESETN_I,
  // access request
  input wire ACC_VALID_I,
  input wire [31:0] ACC_ADDR_I,
  input wire ACC_FETCH_I,
  input wire [2:0] ACC_KIND_I,
  // results
  input wire ACC_DONE_O,
  input wire ACC_BLOCK_O,
  input wire [3:0] OUTER_ATTR_O,
  input wire [3:0] INNER_ATTR_O,
  input wire MEM_FAULT_O,
  input wire ESC_FAULT_O
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESETN_I);
  // address classes of the request
  wire sys = ACC_ADDR_I >= `RPC_SYS_BASE;
  wire private_peripheral_bus = sys && ACC_ADDR_I <= `RPC_PPB_LAST;
  wire sfx = ACC_FETCH_I && sys;
  a_done_next: assert property (ACC_VALID_I |=> ACC_DONE_O)
    else $error("access not answered");
  a_sys_xn: assert property (ACC_VALID_I && sfx |=> ACC_BLOCK_O)
    else $error("fetch from system space passed");
  a_ppb_pass: assert property (ACC_VALID_I && private_peripheral_bus && !ACC_FETCH_I |=> !ACC_BLOCK_O)
    else $error("peripheral bus access blocked");
  a_dbg_pass: assert property (ACC_VALID_I && ACC_KIND_I == 3'h6 && !sfx |=> !ACC_BLOCK_O)
    else $error("plain debug access blocked");
  a_vec_pass: assert property (ACC_VALID_I && ACC_KIND_I == 3'h4 && !sfx |=> !ACC_BLOCK_O)
    else $error("vector read blocked");
  a_one_fault: assert property (ACC_DONE_O && ACC_BLOCK_O |-> MEM_FAULT_O != ESC_FAULT_O)
    else $error("block without exactly one fault");
  a_fault_blk: assert property (MEM_FAULT_O || ESC_FAULT_O |-> ACC_DONE_O && ACC_BLOCK_O)
    else $error("fault without block");
  a_sys_attr: assert property (ACC_VALID_I && sys |=>
    {OUTER_ATTR_O, INNER_ATTR_O} inside {8'h00, 8'h04})
    else $error("system space attribute wrong");
  // main scenarios reached
  cover property (MEM_FAULT_O);
  cover property (ESC_FAULT_O);
  cover property (ACC_DONE_O && !ACC_BLOCK_O);
endmodule // rpc_checker_chk
bind rpc_checker rpc_checker_chk rpc_checker_chk_inst (.CORE_CLK_I(CORE_CLK_I),
  .RESETN_I(RESETN_I), .ACC_VALID_I(ACC_VALID_I), .ACC_ADDR_I(ACC_ADDR_I),
  .ACC_FETCH_I(ACC_FETCH_I), .ACC_KIND_I(ACC_KIND_I), .ACC_DONE_O(ACC_DONE_O),
  .ACC_BLOCK_O(ACC_BLOCK_O), .OUTER_ATTR_O(OUTER_ATTR_O), .INNER_ATTR_O(INNER_ATTR_O),
  .MEM_FAULT_O(MEM_FAULT_O), .ESC_FAULT_O(ESC_FAULT_O));

// [bench/rpc_checker_test.sv]
// rpc_checker_test.sv: random and directed checks of the region checker
// assumes: design, core model and bound checker compiled before it
`include "rpc_map.vh"
module rpc_checker_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, aa = 32'h0, rdat;
  logic [3:0] st = 4'hF;
  logic [2:0] pr = 3'h0, ak = 3'h0;
  logic go = 1'b0, aw = 1'b0, af = 1'b0, ap = 1'b0, bo = 1'b0, pm = 1'b0, tk = 1'b1;
  logic en = 1'b0, bg = 1'b0, hpe = 1'b0, sc = 1'b0;
  logic [1:0] resp;
  logic [16:0] o;
  logic [31:0] rb [4];
  logic [31:0] rl [4];
  wire awr, wry, arr, bv, rv, dn, blk, cal, mf, ef, cm, ce, av, aw_o, af_o, ap_o, as_o;
  wire [1:0] br, rr, sh;
  wire [31:0] rd, aa_o;
  wire [3:0] oa, ia;
  wire [2:0] ak_o;
  int n_errors = 0;
  int tests_run = 0;
  // design and core-side model
  rpc_checker rpc_checker_inst (.CORE_CLK_I(clk), .RESETN_I(rstn), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_AWADDR_I(awa), .S_AXI_AWPROT_I(pr), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wry), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(st), .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(bry), .S_AXI_BRESP_O(br), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARPROT_I(pr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry),
    .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr), .ACC_VALID_I(av), .ACC_ADDR_I(aa_o),
    .ACC_WRITE_I(aw_o), .ACC_FETCH_I(af_o), .ACC_PRIV_I(ap_o), .ACC_SECURE_I(as_o),
    .ACC_KIND_I(ak_o), .HANDLER_BOOSTED_I(bo), .PRIORITY_BOOST_MASK_I(pm),
    .EXC_TAKEABLE_I(tk), .ACC_DONE_O(dn), .ACC_BLOCK_O(blk), .OUTER_ATTR_O(oa),
    .INNER_ATTR_O(ia), .CACHE_ALLOW_O(cal), .SHARE_O(sh), .MEM_FAULT_O(mf),
    .ESC_FAULT_O(ef), .CATCH_MEM_O(cm), .CATCH_EXC_O(ce));
  rpc_core_model rpc_core_model_inst (.clk_i(clk), .go_i(go), .addr_i(aa), .write_i(aw),
    .fetch_i(af), .priv_i(ap), .secure_i(sc), .kind_i(ak), .valid_o(av), .addr_o(aa_o),
    .write_o(aw_o), .fetch_o(af_o), .priv_o(ap_o), .secure_o(as_o), .kind_o(ak_o));
  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // write: both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic pa = 1'b1, pw = 1'b1, ta, tw;
    awa <= {24'h0, a};
    wd <= d;
    st <= s;
    pr <= 3'($urandom);
    awv <= 1'b1;
    wv <= 1'b1;
    while (pa || pw) begin
      @(negedge clk);
      ta = pa && awr;
      tw = pw && wry;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    bry <= 1'b1;
    do @(negedge clk); while (!bv);
    chk(br, a > `RPC_OFF_TYPE ? `RPC_RESP_ERR : `RPC_RESP_OK);
    @(posedge clk);
    bry <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [33:0] e);
    ara <= {24'h0, a};
    arv <= 1'b1;
    do @(negedge clk); while (!arr);
    @(posedge clk);
    arv <= 1'b0;
    rry <= 1'b1;
    do @(negedge clk); while (!rv);
    chk({rr, rd}, e);
    @(posedge clk);
    rry <= 1'b0;
  endtask
  task automatic prog(input int i, input logic [31:0] b, input logic [31:0] l);
    wr(`RPC_OFF_RNUM, 32'(i), 4'hF);
    wr(`RPC_OFF_BASE, b, 4'hF);
    wr(`RPC_OFF_LIMIT, l, 4'hF);
    rb[i] = b;
    rl[i] = l;
  endtask
  // one access; results are one-cycle pulses, caught mid-cycle
  task automatic acc(input logic [31:0] a, input logic [2:0] k, input logic f, p, w);
    aa <= a;
    ak <= k;
    af <= f;
    ap <= p;
    aw <= w;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
    o = {dn, blk, mf, ef, cm, ce, cal, sh, oa, ia};
    @(posedge clk);
  endtask
  // expected block decision for the programmed non-secure regions
  function automatic logic vio(logic [31:0] a, logic f, p, w, logic [2:0] k, logic b);
    int h = 0;
    int j = 0;
    if (f && a >= `RPC_SYS_BASE) return 1'b1;
    if (!en || k == 3'h4 || k == 3'h6 || (b && !hpe) || (a >= `RPC_SYS_BASE &&
      a <= `RPC_PPB_LAST)) return 1'b0;
    for (int i = 0; i < 4; i++)
      if (rl[i][0] && a >= {rb[i][31:5], 5'h00} && a <= {rl[i][31:5], 5'h1F}) begin
        h++;
        j = i;
      end
    if (h != 1) return h > 1 || !(p && bg);
    return (!p && !rb[j][2]) || (w && rb[j][1]) || (f && rb[j][0]) || (f && p && rl[j][4]);
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard, well past the expected run
  initial begin
    #100000;
    n_errors++;
    conclude();
  end
  initial begin
    logic [31:0] a;
    logic f, p, w, lb, lr, lt, v;
    logic [2:0] k;
    logic [31:0] pick [7] = '{32'h20000000, 32'h20007000, 32'h20010000, 32'h30000000,
      32'h50000000, 32'hE0001000, 32'hE0100000};
    logic [7:0] fsb [4] = '{8'h00, 8'h10, 8'h08, 8'h20};
    void'($urandom(32'h2C6F));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rchk(`RPC_OFF_CTRL, 34'h0);
    rchk(8'h2C, 34'h200000000);
    wr(8'h2C, 32'hFFFFFFFF, 4'hF);
    acc(32'h50000000, 3'h0, 1'b0, 1'b0, 1'b1);
    chk(o[15], 1'b0);
    acc(32'hE0000100, 3'h0, 1'b1, 1'b1, 1'b0);
    chk(o[15], 1'b1);
    $display("test reset done");
    // slot 1 shared by regions 0, 1 and 2; region 3 overlaps region 0
    wr(`RPC_OFF_ATTR0, 32'h00004F00, 4'hF);
    wr(`RPC_OFF_HCTRL, 32'h00010000, 4'hF);
    wr(`RPC_OFF_DMON, 32'hFFFF0210, 4'h3);
    prog(0, 32'h2000000C, 32'h20007FE3);
    prog(1, 32'h20010005, 32'h20017FE3);
    prog(2, 32'h30000004, 32'h30000FF3);
    prog(3, 32'h20007004, 32'h20007FE1);
    wr(`RPC_OFF_CTRL, 32'h5, 4'hF);
    en = 1'b1;
    bg = 1'b1;
    rchk(`RPC_OFF_DMON, 34'h210);
    rchk(`RPC_OFF_LIMIT, 34'h20007FE1);
    acc(32'h20000100, 3'h0, 1'b0, 1'b1, 1'b0);
    chk(o[15:0], {1'b0, 4'h0, 3'b101, 8'h4F});
    acc(32'h20010100, 3'h0, 1'b0, 1'b1, 1'b0);
    chk(o[15:0], {1'b0, 4'h0, 3'b100, 8'h4F});
    acc(32'hE0001000, 3'h0, 1'b0, 1'b1, 1'b0);
    chk({o[15], o[7:0]}, {1'b0, 8'h04});
    $display("test attributes done");
    for (int i = 0; i < 300; i++) begin
      a = pick[$urandom % 7] + 32'(($urandom % 64) * 4);
      k = 3'($urandom % 7);
      f = 1'($urandom);
      p = 1'($urandom);
      w = !f && 1'($urandom);
      lb = ($urandom % 4) == 0;
      lr = 1'($urandom);
      lt = 1'($urandom);
      v = vio(a, f, p, w, k, lb);
      bo <= lb && lr;
      pm <= lb && !lr;
      tk <= lt;
      acc(a, k, f, p, w);
      chk(o[16:13], {1'b1, v, v && lt, v && !lt});
    end
    $display("test random done");
    bo <= 1'b0;
    pm <= 1'b0;
    tk <= 1'b1;
    wr(`RPC_OFF_FSTAT, 32'hFF, 4'hF);
    acc(32'h50000040, 3'h0, 1'b0, 1'b0, 1'b1);
    chk(o[12], 1'b1);
    acc(32'h50000080, 3'h0, 1'b1, 1'b0, 1'b0);
    rchk(`RPC_OFF_FSTAT, 34'h83);
    rchk(`RPC_OFF_FADDR, 34'h50000040);
    for (int j = 1; j < 4; j++) begin
      wr(`RPC_OFF_FSTAT, 32'hFF, 4'hF);
      acc(32'h50000000, 3'(j), 1'b0, 1'b0, 1'b1);
      chk(o[11], 1'b1);
      rchk(`RPC_OFF_FSTAT, {26'h0, fsb[j]});
    end
    // the secure unit is still disabled, so the same access passes there
    sc <= 1'b1;
    acc(32'h50000000, 3'h0, 1'b0, 1'b0, 1'b0);
    chk(o[15], 1'b0);
    sc <= 1'b0;
    $display("test status done");
    wr(`RPC_OFF_HCTRL, 32'h0, 4'hF);
    acc(32'h50000000, 3'h0, 1'b0, 1'b0, 1'b0);
    chk(o[14:13], 2'b01);
    wr(`RPC_OFF_CTRL, 32'h7, 4'hF);
    bo <= 1'b1;
    acc(32'h50000000, 3'h0, 1'b0, 1'b0, 1'b0);
    chk(o[15], 1'b1);
    $display("test escalation done");
    conclude();
  end
endmodule // rpc_checker_test

// [bench/rpc_core_model.sv]
// rpc_core_model.sv: core side that issues load, store and fetch checks
// assumes: the bench raises go_i for one cycle per access, on the checker's clock
module rpc_core_model (
  // clock
  input wire clk_i,
  // access from the bench
  input wire go_i,
  input wire [31:0] addr_i,
  input wire write_i,
  input wire fetch_i,
  input wire priv_i,
  input wire secure_i,
  input wire [2:0] kind_i,
  // access to the checker
  output wire valid_o,
  output wire [31:0] addr_o,
  output wire write_o,
  output wire fetch_o,
  output wire priv_o,
  output wire secure_o,
  output wire [2:0] kind_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [38:0] last_reg = 39'h0;
  wire [38:0] cur = {addr_i, write_i, fetch_i, priv_i, secure_i, kind_i};
  // remember the last request so idle lines can show its inverse
  always @(posedge clk_i) begin
    if (go_i) last_reg <= cur;
  end
  // idle fields never repeat the old value, so a stale sample cannot pass
  assign valid_o = go_i;
  assign {addr_o, write_o, fetch_o, priv_o, secure_o, kind_o} = go_i ? cur : ~last_reg;
endmodule // rpc_core_model

// [logic/rpc_checker.v]
// rpc_checker.v: region protection checker with fault recording and an AXI4-Lite slave
// assumes: one clock; access requests come from core logic on the same clock
`include "rpc_map.vh"
// What this block does
// R01 - regions share attribute slots but keep own permission, execute-never, shareability
// R02 - normal memory attributes allow reordering, merging and caching
// R03 - inner and outer cache attributes kept; outer ones exported on sideband
// R04 - cacheable means may cache, never must cache
// R05 - background enable: privileged miss uses default map, unprivileged miss blocked
// R06 - fetch from execute-never region is blocked and faults
// R07 - execute-never comes from the region base register bit
// R08 - privileged fetch from privileged-execute-never region sets instruction violation
// R09 - privileged-execute-never sits at limit register bit 4, both units
// R10 - secure and non-secure units configured independently
// R11 - default map when protection disabled and for vector table reads
// R12 - boosted handlers bypass regions unless handler protection enabled
// R13 - private peripheral bus range always uses default map
// R14 - debug accesses outside unprivileged debug extension bypass checks
// R15 - system space is always execute-never
// R16 - system space is early-ack device, remappable only to strongly ordered
// R17 - dedicated exception only with main extension and enable bit set
// R18 - data violation sets its bit, records address, memory-fault catch
// R19 - instruction violation sets its bit, no address, memory-fault catch
// R20 - violation while stacking sets stacking error, exception-error catch
// R21 - violation while unstacking sets unstacking error, exception-error catch
// R22 - violation during lazy floating-point save sets its bit, exception-error catch
// R23 - address hitting several enabled regions is a violation
// R24 - disabled or untakeable exception escalates to escalated fault
// R25 - status bits stick until cleared; fault address held until next data fault
module rpc_checker #(
  parameter MAIN_EXT = 1
) (
  // clock and reset
  input wire CORE_CLK_I,
  input wire RESETN_I,
  // axi4-lite write address and data
  input wire S_AXI_AWVALID_I,
  output wire S_AXI_AWREADY_O,
  input wire [31:0] S_AXI_AWADDR_I,
  input wire [2:0] S_AXI_AWPROT_I,
  input wire S_AXI_WVALID_I,
  output wire S_AXI_WREADY_O,
  input wire [31:0] S_AXI_WDATA_I,
  input wire [3:0] S_AXI_WSTRB_I,
  // axi4-lite write response
  output reg S_AXI_BVALID_O,
  input wire S_AXI_BREADY_I,
  output reg [1:0] S_AXI_BRESP_O,
  // axi4-lite read
  input wire S_AXI_ARVALID_I,
  output wire S_AXI_ARREADY_O,
  input wire [31:0] S_AXI_ARADDR_I,
  input wire [2:0] S_AXI_ARPROT_I,
  output reg S_AXI_RVALID_O,
  input wire S_AXI_RREADY_I,
  output reg [31:0] S_AXI_RDATA_O,
  output reg [1:0] S_AXI_RRESP_O,
  // access request from the core
  input wire ACC_VALID_I,
  input wire [31:0] ACC_ADDR_I,
  input wire ACC_WRITE_I,
  input wire ACC_FETCH_I,
  input wire ACC_PRIV_I,
  input wire ACC_SECURE_I,
  input wire [2:0] ACC_KIND_I,
  // execution context
  input wire HANDLER_BOOSTED_I,
  input wire PRIORITY_BOOST_MASK_I,
  input wire EXC_TAKEABLE_I,
  // check result
  output reg ACC_DONE_O,
  output reg ACC_BLOCK_O,
  output reg [3:0] OUTER_ATTR_O,
  output reg [3:0] INNER_ATTR_O,
  output reg CACHE_ALLOW_O,
  output reg [1:0] SHARE_O,
  // fault signalling
  output reg MEM_FAULT_O,
  output reg ESC_FAULT_O,
  output reg CATCH_MEM_O,
  output reg CATCH_EXC_O
);
  // bank 1 holds the secure unit, bank 0 the non-secure one
  reg [31:0] ctrl_reg [0:1];
  reg [31:0] attr0_reg [0:1];
  reg [31:0] attr1_reg [0:1];
  reg [3:0] rnum_reg;
  reg [7:0] fstat_reg;
  reg [31:0] faddr_reg;
  reg [31:0] hctrl_reg;
  reg [31:0] dmon_reg;
  reg aw_full_reg;
  reg w_full_reg;
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  wire [31:0] rbase [0:7];
  wire [31:0] rlimit [0:7];
  wire [7:0] hit;
  reg [7:0] wr_base;
  reg [7:0] wr_limit;
  reg [31:0] wr_word;
  reg wr_ok;
  reg [31:0] rd_word;
  reg rd_ok;
  reg [7:0] fstat_next;
  reg [7:0] fs_set;
  reg [7:0] fs_clr;
  reg bank;
  reg [2:0] hits;
  reg [1:0] sel;
  reg [31:0] s_base;
  reg [31:0] s_limit;
  reg bypass;
  reg viol;
  reg [7:0] attr;
  reg [63:0] attr_all;
  wire do_write;
  wire take;
  integer i;

  // byte-lane merge of a bus write into an old word
  function [31:0] f_merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer k;
    begin
      f_merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          f_merge[k*8 +: 8] = data[k*8 +: 8];
        end
      end
    end
  endfunction

  // system space test, used for execute-never, type remap and the peripheral bus range
  function f_sys;
    input [31:0] a;
    begin
      f_sys = (a >= `RPC_SYS_BASE);
    end
  endfunction

  // eight region stores, regions 0-3 non-secure, 4-7 secure
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_region
      rpc_region u_region (
        .clk_i(CORE_CLK_I),
        .rstn_i(RESETN_I),
        .wr_base_i(wr_base[g]),
        .wr_limit_i(wr_limit[g]),
        .wdata_i(wr_word),
        .addr_i(ACC_ADDR_I),
        .base_o(rbase[g]),
        .limit_o(rlimit[g]),
        .hit_o(hit[g])
      );
    end
  endgenerate

  // bus handshakes; a pending write response stalls new writes, a pending read response new reads
  assign S_AXI_AWREADY_O = !aw_full_reg && !S_AXI_BVALID_O;
  assign S_AXI_WREADY_O = !w_full_reg && !S_AXI_BVALID_O;
  assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;
  assign do_write = aw_full_reg && w_full_reg && !S_AXI_BVALID_O;

  // write decode; region selection by number register bits 2:0, bank in bit 2, bit 3 set blocks region writes
  always @* begin
    wr_base = 8'h00;
    wr_limit = 8'h00;
    wr_word = f_merge(`RPC_RST_WORD, w_data_reg, w_strb_reg);
    wr_ok = 1'b1;
    case (aw_addr_reg)
      `RPC_OFF_BASE: begin
        wr_word = f_merge(rbase[rnum_reg[2:0]], w_data_reg, w_strb_reg);
        wr_base[rnum_reg[2:0]] = do_write && !rnum_reg[3];
      end
      `RPC_OFF_LIMIT: begin
        wr_word = f_merge(rlimit[rnum_reg[2:0]], w_data_reg, w_strb_reg);
        wr_limit[rnum_reg[2:0]] = do_write && !rnum_reg[3];
      end
      `RPC_OFF_CTRL, `RPC_OFF_RNUM, `RPC_OFF_ATTR0, `RPC_OFF_ATTR1, `RPC_OFF_FSTAT,
      `RPC_OFF_FADDR, `RPC_OFF_HCTRL, `RPC_OFF_DMON, `RPC_OFF_TYPE: begin
        wr_ok = 1'b1;
      end
      default: begin
        wr_ok = 1'b0;
      end
    endcase
  end

  // read decode; banked registers follow the bank bit of the number register
  always @* begin
    rd_ok = 1'b1;
    case (S_AXI_ARADDR_I[7:0])
      `RPC_OFF_CTRL: rd_word = ctrl_reg[rnum_reg[2]];
      `RPC_OFF_RNUM: rd_word = {28'h0000000, rnum_reg};
      `RPC_OFF_BASE: rd_word = rbase[rnum_reg[2:0]];
      `RPC_OFF_LIMIT: rd_word = rlimit[rnum_reg[2:0]];
      `RPC_OFF_ATTR0: rd_word = attr0_reg[rnum_reg[2]];
      `RPC_OFF_ATTR1: rd_word = attr1_reg[rnum_reg[2]];
      `RPC_OFF_FSTAT: rd_word = {24'h000000, fstat_reg};
      `RPC_OFF_FADDR: rd_word = faddr_reg;
      `RPC_OFF_HCTRL: rd_word = hctrl_reg;
      `RPC_OFF_DMON: rd_word = dmon_reg;
      `RPC_OFF_TYPE: rd_word = `RPC_TYPE_VAL;
      default: begin
        rd_word = `RPC_RST_WORD;
        rd_ok = 1'b0;
      end
    endcase
  end

  // region lookup for the unit of the access's security state
  always @* begin
    bank = ACC_SECURE_I; // R10
    hits = 3'h0;
    sel = 2'h0;
    for (i = 0; i < `RPC_REGIONS; i = i + 1) begin
      if (hit[{bank, i[1:0]}]) begin
        hits = hits + 3'h1;
        sel = i[1:0];
      end
    end
    s_base = rbase[{bank, sel}];
    s_limit = rlimit[{bank, sel}];
    attr_all = {attr1_reg[bank], attr0_reg[bank]};
  end

  // permission check; forced default-map cases skip the regions entirely
  always @* begin
    bypass = !ctrl_reg[bank][`RPC_CTRL_EN] || // R11
      (ACC_KIND_I == `RPC_K_VECTOR) || // R11
      ((HANDLER_BOOSTED_I || PRIORITY_BOOST_MASK_I) && !ctrl_reg[bank][`RPC_CTRL_HPE]) || // R12
      (f_sys(ACC_ADDR_I) && ACC_ADDR_I <= `RPC_PPB_LAST) || // R13
      (ACC_KIND_I == `RPC_K_DBG_OTHER); // R14
    if (bypass) begin
      viol = 1'b0;
    end else if (hits == 3'h0) begin
      viol = !(ACC_PRIV_I && ctrl_reg[bank][`RPC_CTRL_BGEN]); // R05
    end else if (hits != 3'h1) begin
      viol = 1'b1; // R23
    end else begin
      // each region keeps its own permissions even when attributes are shared
      viol = (!ACC_PRIV_I && !s_base[`RPC_BASE_APU]) || // R01
        (ACC_WRITE_I && s_base[`RPC_BASE_APW]) ||
        (ACC_FETCH_I && s_base[`RPC_BASE_XN]) || // R06 R07
        (ACC_FETCH_I && ACC_PRIV_I && s_limit[`RPC_LIM_PXN]); // R08 R09
    end
    if (ACC_FETCH_I && f_sys(ACC_ADDR_I)) begin
      viol = 1'b1; // R15
    end
    // attribute: slot picked by limit register bits 3:1, several regions may share a slot
    if (bypass || hits != 3'h1) begin
      attr = ACC_ADDR_I <= `RPC_CODE_LAST ? `RPC_ATTR_NORMAL : `RPC_ATTR_EARLY;
    end else begin
      attr = attr_all[{s_limit[3:1], 3'h0} +: 8]; // R01
    end
    if (f_sys(ACC_ADDR_I) && attr != `RPC_ATTR_STRONG) begin
      attr = `RPC_ATTR_EARLY; // R16
    end
  end

  // fault status: sticky bits, a new event wins over a same-cycle clear
  always @* begin
    fs_set = 8'h00;
    if (ACC_VALID_I && viol) begin
      case (ACC_KIND_I)
        `RPC_K_STACK: fs_set[`RPC_FS_STK] = 1'b1; // R20
        `RPC_K_UNSTACK: fs_set[`RPC_FS_UNSTK] = 1'b1; // R21
        `RPC_K_LAZYFP: fs_set[`RPC_FS_LSP] = 1'b1; // R22
        default: begin
          if (ACC_FETCH_I) begin
            fs_set[`RPC_FS_IACC] = 1'b1; // R19
          end else begin
            fs_set[`RPC_FS_DACC] = 1'b1; // R18
            fs_set[`RPC_FS_FAVALID] = 1'b1;
          end
        end
      endcase
    end
    fs_clr = 8'h00;
    if (do_write && aw_addr_reg == `RPC_OFF_FSTAT) begin
      fs_clr = wr_word[7:0];
    end
    fstat_next = (fstat_reg & ~fs_clr) | fs_set; // R25
  end

  // dedicated exception needs the extension, its enable, and a takeable priority
  assign take = (MAIN_EXT != 0) && hctrl_reg[`RPC_HC_MVEN] && EXC_TAKEABLE_I; // R17

  // bus slave registers and software-programmed state
  always @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= `RPC_RST_WORD;
      w_strb_reg <= 4'h0;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= `RPC_RESP_OK;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= `RPC_RST_WORD;
      S_AXI_RRESP_O <= `RPC_RESP_OK;
      ctrl_reg[0] <= `RPC_RST_WORD;
      ctrl_reg[1] <= `RPC_RST_WORD;
      attr0_reg[0] <= `RPC_RST_WORD;
      attr0_reg[1] <= `RPC_RST_WORD;
      attr1_reg[0] <= `RPC_RST_WORD;
      attr1_reg[1] <= `RPC_RST_WORD;
      rnum_reg <= 4'h0;
      hctrl_reg <= `RPC_RST_WORD;
      dmon_reg <= `RPC_RST_WORD;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR_I[7:0];
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_full_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA_I;
        w_strb_reg <= S_AXI_WSTRB_I;
      end
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O <= wr_ok ? `RPC_RESP_OK : `RPC_RESP_ERR;
        case (aw_addr_reg)
          `RPC_OFF_CTRL: ctrl_reg[rnum_reg[2]] <= {29'h00000000, wr_word[2:0]};
          `RPC_OFF_RNUM: rnum_reg <= wr_word[3:0];
          `RPC_OFF_ATTR0: attr0_reg[rnum_reg[2]] <= wr_word;
          `RPC_OFF_ATTR1: attr1_reg[rnum_reg[2]] <= wr_word;
          `RPC_OFF_HCTRL: hctrl_reg <= wr_word & (32'h00000001 << `RPC_HC_MVEN);
          `RPC_OFF_DMON: dmon_reg <= wr_word;
          default: rnum_reg <= rnum_reg;
        endcase
      end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RDATA_O <= rd_word;
        S_AXI_RRESP_O <= rd_ok ? `RPC_RESP_OK : `RPC_RESP_ERR;
      end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
      end
    end
  end

  // fault recording; the address is kept until the next data fault
  always @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      fstat_reg <= 8'h00;
      faddr_reg <= `RPC_RST_WORD;
    end else begin
      fstat_reg <= fstat_next; // R25
      if (fs_set[`RPC_FS_DACC]) begin
        faddr_reg <= ACC_ADDR_I; // R18
      end
    end
  end

  // registered result, one cycle after the request
  always @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ACC_DONE_O <= 1'b0;
      ACC_BLOCK_O <= 1'b0;
      OUTER_ATTR_O <= 4'h0;
      INNER_ATTR_O <= 4'h0;
      CACHE_ALLOW_O <= 1'b0;
      SHARE_O <= 2'h0;
      MEM_FAULT_O <= 1'b0;
      ESC_FAULT_O <= 1'b0;
      CATCH_MEM_O <= 1'b0;
      CATCH_EXC_O <= 1'b0;
    end else begin
      ACC_DONE_O <= ACC_VALID_I;
      ACC_BLOCK_O <= ACC_VALID_I && viol; // R06
      OUTER_ATTR_O <= attr[7:4]; // R03
      INNER_ATTR_O <= attr[3:0]; // R03
      // normal memory only grants leave to reorder, merge and cache; the cache decides
      CACHE_ALLOW_O <= (attr[7:4] != 4'h0) && !viol; // R02 R04
      SHARE_O <= (bypass || hits != 3'h1) ? 2'h0 : s_base[4:3]; // R01
      MEM_FAULT_O <= ACC_VALID_I && viol && take; // R17
      ESC_FAULT_O <= ACC_VALID_I && viol && !take; // R24
      CATCH_MEM_O <= dmon_reg[`RPC_DM_CMEM] &&
        (fs_set[`RPC_FS_IACC] || fs_set[`RPC_FS_DACC]); // R18 R19
      CATCH_EXC_O <= dmon_reg[`RPC_DM_CEXC] &&
        (fs_set[`RPC_FS_STK] || fs_set[`RPC_FS_UNSTK] || fs_set[`RPC_FS_LSP]); // R20 R21 R22
    end
  end
endmodule // rpc_checker

// [logic/rpc_map.vh]
// rpc_map.vh: offsets, field positions, reset values and encodings of the region checker
// assumes: included by the checker and its region store, all byte offsets on a 32-bit bus
`ifndef RPC_MAP_VH
`define RPC_MAP_VH
// register byte offsets
`define RPC_OFF_CTRL 8'h00
`define RPC_OFF_RNUM 8'h04
`define RPC_OFF_BASE 8'h08
`define RPC_OFF_LIMIT 8'h0C
`define RPC_OFF_ATTR0 8'h10
`define RPC_OFF_ATTR1 8'h14
`define RPC_OFF_FSTAT 8'h18
`define RPC_OFF_FADDR 8'h1C
`define RPC_OFF_HCTRL 8'h20
`define RPC_OFF_DMON 8'h24
`define RPC_OFF_TYPE 8'h28
// control bits
`define RPC_CTRL_EN 0
`define RPC_CTRL_HPE 1
`define RPC_CTRL_BGEN 2
// base register fields
`define RPC_BASE_XN 0
`define RPC_BASE_APW 1
`define RPC_BASE_APU 2
// limit register fields
`define RPC_LIM_EN 0
`define RPC_LIM_PXN 4
// fault status bits
`define RPC_FS_IACC 0
`define RPC_FS_DACC 1
`define RPC_FS_UNSTK 3
`define RPC_FS_STK 4
`define RPC_FS_LSP 5
`define RPC_FS_FAVALID 7
// handler control and debug monitor bits
`define RPC_HC_MVEN 16
`define RPC_DM_CMEM 4
`define RPC_DM_CEXC 9
// access kinds
`define RPC_K_NORMAL 3'h0
`define RPC_K_STACK 3'h1
`define RPC_K_UNSTACK 3'h2
`define RPC_K_LAZYFP 3'h3
`define RPC_K_VECTOR 3'h4
`define RPC_K_DBG_UDE 3'h5
`define RPC_K_DBG_OTHER 3'h6
// address map and attributes
`define RPC_SYS_BASE 32'hE0000000
`define RPC_PPB_LAST 32'hE00FFFFF
`define RPC_CODE_LAST 32'h3FFFFFFF
`define RPC_ATTR_STRONG 8'h00
`define RPC_ATTR_EARLY 8'h04
`define RPC_ATTR_NORMAL 8'hFF
// geometry and reset values
`define RPC_REGIONS 4
`define RPC_TYPE_VAL 32'h00000404
`define RPC_RST_WORD 32'h00000000
`define RPC_RESP_OK 2'b00
`define RPC_RESP_ERR 2'b10
`endif

// [logic/rpc_region.v]
// rpc_region.v: one protection region, its base and limit words and its address match
// assumes: written by the checker's bus slave with byte lanes already merged
`include "rpc_map.vh"
module rpc_region (
  // clock and reset
  input wire clk_i,
  input wire rstn_i,
  // programming
  input wire wr_base_i,
  input wire wr_limit_i,
  input wire [31:0] wdata_i,
  // lookup
  input wire [31:0] addr_i,
  output wire [31:0] base_o,
  output wire [31:0] limit_o,
  output wire hit_o
);
  reg [31:0] base_reg;
  reg [31:0] limit_reg;

  // region words, both cleared so a region starts disabled
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      base_reg <= `RPC_RST_WORD;
      limit_reg <= `RPC_RST_WORD;
    end else begin
      if (wr_base_i) begin
        base_reg <= wdata_i;
      end
      if (wr_limit_i) begin
        limit_reg <= wdata_i;
      end
    end
  end

  // 32-byte granules, limit inclusive
  assign hit_o = limit_reg[`RPC_LIM_EN] && (addr_i[31:5] >= base_reg[31:5]) &&
    (addr_i[31:5] <= limit_reg[31:5]);
  assign base_o = base_reg;
  assign limit_o = limit_reg;
endmodule // rpc_region
